// >>> tlmb_pkg.sv
package tlmb_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int MASK_W = DATA_W / 8;
    localparam int SRC_W = 4;
    localparam int SIZE_W = 3;
    localparam int PARAM_W = 3;
    localparam int CNT_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int MEM_WORDS = 64;

    // log2 of bytes per beat
    localparam logic [SIZE_W-1:0] BEAT_LG = 3'h2;
    localparam logic [SIZE_W-1:0] MAX_LG_RST = 3'h5;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

    typedef enum logic [2:0] {
        TLMB_PUT_FULL = 3'h0,
        TLMB_PUT_PART = 3'h1,
        TLMB_ARITH = 3'h2,
        TLMB_LOGIC = 3'h3,
        TLMB_GET = 3'h4,
        TLMB_HINT = 3'h5
    } tlmb_a_op_t;

    typedef enum logic [2:0] {
        TLMB_ACK = 3'h0,
        TLMB_ACK_DATA = 3'h1,
        TLMB_HINT_ACK = 3'h2
    } tlmb_d_op_t;

    typedef enum logic [2:0] {
        TLMB_REQ_GET = 3'h0,
        TLMB_REQ_PUT = 3'h1,
        TLMB_REQ_ARITH = 3'h2,
        TLMB_REQ_LOGIC = 3'h3,
        TLMB_REQ_HINT = 3'h4
    } tlmb_req_t;

    // atomic_op_codes
    localparam logic [PARAM_W-1:0] AT_MIN = 3'h0;
    localparam logic [PARAM_W-1:0] AT_MAX = 3'h1;
    localparam logic [PARAM_W-1:0] AT_MINU = 3'h2;
    localparam logic [PARAM_W-1:0] AT_MAXU = 3'h3;
    localparam logic [PARAM_W-1:0] AT_ADD = 3'h4;
    localparam logic [PARAM_W-1:0] AT_XOR = 3'h0;
    localparam logic [PARAM_W-1:0] AT_OR = 3'h1;
    localparam logic [PARAM_W-1:0] AT_AND = 3'h2;
    localparam logic [PARAM_W-1:0] AT_SWAP = 3'h3;

    // prefetch_hint_codes
    localparam logic [PARAM_W-1:0] HINT_READ = 3'h0;
    localparam logic [PARAM_W-1:0] HINT_WRITE = 3'h1;

    typedef struct packed {
        tlmb_a_op_t op;
        logic [PARAM_W-1:0] param;
        logic [SIZE_W-1:0] size_log2;
        logic [SRC_W-1:0] source_id;
        logic [ADDR_W-1:0] target_address;
        logic [MASK_W-1:0] mask;
        logic [DATA_W-1:0] data;
    } tlmb_a_beat_t;

    function automatic logic has_data_a(input tlmb_a_op_t op);
        return op == TLMB_PUT_FULL || op == TLMB_PUT_PART
            || op == TLMB_ARITH || op == TLMB_LOGIC;
    endfunction

    function automatic logic has_data_d(input tlmb_d_op_t op);
        return op == TLMB_ACK_DATA;
    endfunction

    // beats in a message minus one; dataless messages are one beat
    function automatic logic [CNT_W-1:0] beats1(
        input logic [SIZE_W-1:0] size_log2,
        input logic data
    );
        logic [SIZE_W-1:0] sh;
        sh = size_log2 - BEAT_LG;
        if (!data || size_log2 <= BEAT_LG)
            return CNT_RST;
        return (8'h01 << sh) - 8'h01;
    endfunction

endpackage

// >>> tlmb_if.sv
`timescale 1ns/100ps
interface tlmb_if;
    logic a_valid;
    logic a_ready;
    logic [2:0] a_opcode;
    logic [tlmb_pkg::PARAM_W-1:0] a_param;
    logic [tlmb_pkg::SIZE_W-1:0] a_size;
    logic [tlmb_pkg::SRC_W-1:0] a_source;
    logic [tlmb_pkg::ADDR_W-1:0] a_address;
    logic [tlmb_pkg::MASK_W-1:0] a_mask;
    logic [tlmb_pkg::DATA_W-1:0] a_data;
    logic d_valid;
    logic d_ready;
    logic [2:0] d_opcode;
    logic [tlmb_pkg::SIZE_W-1:0] d_size;
    logic [tlmb_pkg::SRC_W-1:0] d_source;
    logic [tlmb_pkg::DATA_W-1:0] d_data;

    modport client (
        output a_valid, a_opcode, a_param, a_size, a_source,
        output a_address, a_mask, a_data, d_ready,
        input a_ready, d_valid, d_opcode, d_size, d_source, d_data
    );
    modport manager (
        input a_valid, a_opcode, a_param, a_size, a_source,
        input a_address, a_mask, a_data, d_ready,
        output a_ready, d_valid, d_opcode, d_size, d_source, d_data
    );
endinterface

// >>> tlmb_fifo.sv
`timescale 1ns/100ps
module tlmb_fifo #(
    parameter int WIDTH = 81,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        return (p == LAST) ? '0 : p + 1'b1;
    endfunction

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rd_q];

    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            if (push)
                wr_q <= inc(wr_q);
            if (pop)
                rd_q <= inc(rd_q);
            cnt_q <= cnt_d;
            // registered so the ready port is a flop; full stays honest
            in_ready <= cnt_d != FULL;
        end
    end
endmodule

// >>> tlmb_manager.sv
// Functional notes
// - Get answered with possibly multi-beat AccessAckData
// - write with mask is PutPartial, else PutFull
// - multi-beat put changes only data and mask
// - complete put gets exactly one AccessAck
// - arithmetic min/max/minu/maxu/add, returns old value
// - logical xor/or/and/swap, returns old value
// - request data is right-hand operand
// - read hint shared, write hint exclusive
// - last-level cache treats both hints alike
// - non-cache manager only acknowledges hints
// - every hint answered with HintAck
// - ack has data only for Get and atomics, not for puts or hints
// - request builder outputs legality flag
// - size field is log2 of byte count
// - first-beat flag on watched channel
// - last-beat flag on A channel; d_last is registered from the previous cycle's count
// - done only on fire of last beat
// - beat index output, opening beat zero
// - data messages: puts, atomics, AccessAckData
`timescale 1ns/100ps
module tlmb_manager #(
    parameter bit IS_CACHE = 1'b0,
    parameter bit IS_LLC = 1'b0,
    parameter int DEPTH = tlmb_pkg::FIFO_DEPTH,
    parameter int WORDS = tlmb_pkg::MEM_WORDS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    tlmb_if.manager bus,
    output logic a_first,
    output logic a_last,
    output logic a_done,
    output logic [tlmb_pkg::CNT_W-1:0] a_count,
    output logic d_first,
    output logic d_last,
    output logic d_done,
    output logic [tlmb_pkg::CNT_W-1:0] d_count,
    output logic pf_valid,
    output logic pf_exclusive,
    output logic [tlmb_pkg::ADDR_W-1:0] pf_address
);
    localparam int W = $bits(tlmb_pkg::tlmb_a_beat_t);
    localparam int IW = $clog2(WORDS);
    localparam int DW = tlmb_pkg::DATA_W;
    localparam int CW = tlmb_pkg::CNT_W;

    typedef enum logic {
        TLMB_ST_IDLE = 1'b0,
        TLMB_ST_GET = 1'b1
    } tlmb_mgr_state_t;

    tlmb_mgr_state_t state_q;
    tlmb_mgr_state_t state_d;
    tlmb_pkg::tlmb_a_beat_t in_beat;
    tlmb_pkg::tlmb_a_beat_t head;
    logic [W-1:0] head_raw;
    logic head_valid;
    logic pop;
    logic fifo_ready;
    logic [DW-1:0] mem [WORDS];
    logic [CW-1:0] op_cnt_q;
    logic [CW-1:0] head_b1;
    logic [CW-1:0] get_cnt_q;
    logic [CW-1:0] get_b1_q;
    logic [tlmb_pkg::SIZE_W-1:0] get_size_q;
    logic [tlmb_pkg::SRC_W-1:0] get_src_q;
    logic [IW-1:0] get_idx_q;
    logic [IW-1:0] head_idx;
    logic [DW-1:0] old_word;
    logic slot_free;
    logic emit;
    tlmb_pkg::tlmb_d_op_t emit_op;
    logic [DW-1:0] emit_data;
    logic [tlmb_pkg::SIZE_W-1:0] emit_size;
    logic [tlmb_pkg::SRC_W-1:0] emit_src;
    logic mem_we;
    logic [DW-1:0] mem_wdata;
    logic [tlmb_pkg::CNT_W-1:0] a_b1;
    logic [tlmb_pkg::CNT_W-1:0] d_b1;
    logic a_fire;
    logic d_fire;

    function automatic logic [IW-1:0] word_idx(
        input logic [tlmb_pkg::ADDR_W-1:0] addr,
        input logic [CW-1:0] beat
    );
        return IW'(addr[tlmb_pkg::ADDR_W-1:2] + beat);
    endfunction

    function automatic logic [DW-1:0] merge(
        input logic [DW-1:0] old,
        input logic [DW-1:0] nw,
        input logic [tlmb_pkg::MASK_W-1:0] mask
    );
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < tlmb_pkg::MASK_W; i++)
            if (mask[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    // old value on the left, request data on the right
    function automatic logic [DW-1:0] alu(
        input logic arith,
        input logic [tlmb_pkg::PARAM_W-1:0] p,
        input logic [DW-1:0] old,
        input logic [DW-1:0] rhs
    );
        logic lt_s;
        logic lt_u;
        lt_s = $signed(old) < $signed(rhs);
        lt_u = old < rhs;
        if (arith)
            case (p)
                tlmb_pkg::AT_MIN: return lt_s ? old : rhs;
                tlmb_pkg::AT_MAX: return lt_s ? rhs : old;
                tlmb_pkg::AT_MINU: return lt_u ? old : rhs;
                tlmb_pkg::AT_MAXU: return lt_u ? rhs : old;
                tlmb_pkg::AT_ADD: return old + rhs;
                default: return old;
            endcase
        case (p)
            tlmb_pkg::AT_XOR: return old ^ rhs;
            tlmb_pkg::AT_OR: return old | rhs;
            tlmb_pkg::AT_AND: return old & rhs;
            tlmb_pkg::AT_SWAP: return rhs;
            default: return old;
        endcase
    endfunction

    assign in_beat = '{op: tlmb_pkg::tlmb_a_op_t'(bus.a_opcode),
        param: bus.a_param, size_log2: bus.a_size,
        source_id: bus.a_source, target_address: bus.a_address,
        mask: bus.a_mask, data: bus.a_data};
    assign head = tlmb_pkg::tlmb_a_beat_t'(head_raw);

    tlmb_fifo #(
        .WIDTH(W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(bus.a_valid),
        .in_ready(fifo_ready),
        .in_data(W'(in_beat)),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head_raw)
    );
    assign bus.a_ready = fifo_ready;

    // address is held across put beats, so step by the beat index
    assign head_b1 = tlmb_pkg::beats1(head.size_log2,
        tlmb_pkg::has_data_a(head.op));
    assign head_idx = word_idx(head.target_address, op_cnt_q);
    assign old_word = mem[head_idx];
    assign slot_free = !bus.d_valid || bus.d_ready;

    always_comb
    begin
        state_d = state_q;
        pop = 1'b0;
        emit = 1'b0;
        emit_op = tlmb_pkg::TLMB_ACK;
        emit_data = '0;
        emit_size = head.size_log2;
        emit_src = head.source_id;
        mem_we = 1'b0;
        mem_wdata = old_word;
        case (state_q)
            TLMB_ST_IDLE:
                if (head_valid && slot_free)
                begin
                    pop = 1'b1;
                    case (head.op)
                        tlmb_pkg::TLMB_GET:
                            state_d = TLMB_ST_GET;
                        tlmb_pkg::TLMB_PUT_FULL, tlmb_pkg::TLMB_PUT_PART:
                        begin
                            mem_we = 1'b1;
                            mem_wdata = merge(old_word, head.data,
                                head.mask);
                            emit = op_cnt_q == head_b1;
                        end
                        tlmb_pkg::TLMB_ARITH, tlmb_pkg::TLMB_LOGIC:
                        begin
                            mem_we = 1'b1;
                            mem_wdata = merge(old_word,
                                alu(head.op == tlmb_pkg::TLMB_ARITH,
                                head.param, old_word, head.data),
                                head.mask);
                            emit = 1'b1;
                            emit_op = tlmb_pkg::TLMB_ACK_DATA;
                            emit_data = old_word;
                        end
                        default:
                        begin
                            emit = 1'b1;
                            emit_op = tlmb_pkg::TLMB_HINT_ACK;
                        end
                    endcase
                end
            TLMB_ST_GET:
                if (slot_free)
                begin
                    emit = 1'b1;
                    emit_op = tlmb_pkg::TLMB_ACK_DATA;
                    emit_data = mem[IW'(get_idx_q + get_cnt_q)];
                    emit_size = get_size_q;
                    emit_src = get_src_q;
                    if (get_cnt_q == get_b1_q)
                        state_d = TLMB_ST_IDLE;
                end
            default:
                state_d = TLMB_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
            mem[head_idx] <= mem_wdata;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= TLMB_ST_IDLE;
            op_cnt_q <= tlmb_pkg::CNT_RST;
            get_cnt_q <= tlmb_pkg::CNT_RST;
            get_b1_q <= tlmb_pkg::CNT_RST;
            get_size_q <= '0;
            get_src_q <= '0;
            get_idx_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            if (pop)
                op_cnt_q <= (op_cnt_q == head_b1) ? tlmb_pkg::CNT_RST
                    : op_cnt_q + 1'b1;
            if (pop && head.op == tlmb_pkg::TLMB_GET)
            begin
                get_cnt_q <= tlmb_pkg::CNT_RST;
                get_b1_q <= tlmb_pkg::beats1(head.size_log2, 1'b1);
                get_size_q <= head.size_log2;
                get_src_q <= head.source_id;
                get_idx_q <= word_idx(head.target_address,
                    tlmb_pkg::CNT_RST);
            end
            else if (state_q == TLMB_ST_GET && emit)
                get_cnt_q <= get_cnt_q + 1'b1;
        end
    end

    // source and size echo the acknowledged request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus.d_valid <= 1'b0;
            bus.d_opcode <= tlmb_pkg::TLMB_ACK;
            bus.d_size <= '0;
            bus.d_source <= '0;
            bus.d_data <= '0;
        end
        else if (slot_free)
        begin
            bus.d_valid <= emit;
            bus.d_opcode <= emit_op;
            bus.d_size <= emit_size;
            bus.d_source <= emit_src;
            bus.d_data <= emit_data;
        end
    end

    // hint side effects; a plain memory does nothing but acknowledge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pf_valid <= 1'b0;
            pf_exclusive <= 1'b0;
            pf_address <= '0;
        end
        else
        begin
            pf_valid <= IS_CACHE && pop
                && head.op == tlmb_pkg::TLMB_HINT;
            if (pop && head.op == tlmb_pkg::TLMB_HINT)
            begin
                pf_exclusive <= !IS_LLC
                    && head.param == tlmb_pkg::HINT_WRITE;
                pf_address <= head.target_address;
            end
        end
    end

    assign a_fire = bus.a_valid && fifo_ready;
    assign d_fire = bus.d_valid && bus.d_ready;
    assign a_b1 = tlmb_pkg::beats1(bus.a_size,
        tlmb_pkg::has_data_a(tlmb_pkg::tlmb_a_op_t'(bus.a_opcode)));
    assign d_b1 = tlmb_pkg::beats1(bus.d_size,
        tlmb_pkg::has_data_d(tlmb_pkg::tlmb_d_op_t'(bus.d_opcode)));

    // beat trackers, registered: first flags follow the current count, done flags the previous cycle's fire
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_count <= tlmb_pkg::CNT_RST;
            a_first <= 1'b1;
            a_last <= 1'b0;
            a_done <= 1'b0;
        end
        else
        begin
            if (a_fire)
                a_count <= (a_count == a_b1) ? tlmb_pkg::CNT_RST
                    : a_count + 1'b1;
            a_first <= a_fire ? a_count == a_b1
                : a_count == tlmb_pkg::CNT_RST;
            a_last <= a_fire ? (a_count + 1'b1 == a_b1 || a_count == a_b1)
                : a_count == a_b1;
            a_done <= a_fire && a_count == a_b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            d_count <= tlmb_pkg::CNT_RST;
            d_first <= 1'b1;
            d_last <= 1'b0;
            d_done <= 1'b0;
        end
        else
        begin
            if (d_fire)
                d_count <= (d_count == d_b1) ? tlmb_pkg::CNT_RST
                    : d_count + 1'b1;
            d_first <= d_fire ? d_count == d_b1
                : d_count == tlmb_pkg::CNT_RST;
            d_last <= d_count == d_b1;
            d_done <= d_fire && d_count == d_b1;
        end
    end
endmodule

// >>> tlmb_client.sv
`timescale 1ns/100ps
module tlmb_client #(
    parameter logic [5:0] SUPPORTS = 6'h3f,
    parameter logic [tlmb_pkg::SIZE_W-1:0] MAX_LG = tlmb_pkg::MAX_LG_RST
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    tlmb_if.client bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire tlmb_pkg::tlmb_req_t req_kind,
    input wire logic [tlmb_pkg::PARAM_W-1:0] req_param,
    input wire logic [tlmb_pkg::SIZE_W-1:0] req_size,
    input wire logic [tlmb_pkg::SRC_W-1:0] req_source,
    input wire logic [tlmb_pkg::ADDR_W-1:0] req_address,
    input wire logic [tlmb_pkg::DATA_W-1:0] req_data,
    input wire logic [tlmb_pkg::MASK_W-1:0] req_mask,
    input wire logic req_mask_en,
    output logic legal,
    output logic rsp_valid,
    output logic [2:0] rsp_opcode,
    output logic [tlmb_pkg::SRC_W-1:0] rsp_source,
    output logic [tlmb_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_first,
    output logic rsp_last,
    output logic rsp_done,
    output logic [tlmb_pkg::CNT_W-1:0] rsp_count
);
    tlmb_pkg::tlmb_a_op_t op;
    logic accept;
    logic d_fire;
    logic [tlmb_pkg::CNT_W-1:0] beat_q;
    logic [tlmb_pkg::CNT_W-1:0] b1;
    logic [tlmb_pkg::CNT_W-1:0] d_b1;
    logic [tlmb_pkg::ADDR_W-1:0] align;

    always_comb
    begin
        case (req_kind)
            tlmb_pkg::TLMB_REQ_GET: op = tlmb_pkg::TLMB_GET;
            tlmb_pkg::TLMB_REQ_PUT: op = req_mask_en
                ? tlmb_pkg::TLMB_PUT_PART : tlmb_pkg::TLMB_PUT_FULL;
            tlmb_pkg::TLMB_REQ_ARITH: op = tlmb_pkg::TLMB_ARITH;
            tlmb_pkg::TLMB_REQ_LOGIC: op = tlmb_pkg::TLMB_LOGIC;
            default: op = tlmb_pkg::TLMB_HINT;
        endcase
    end

    assign accept = req_valid && req_ready;
    assign b1 = tlmb_pkg::beats1(req_size, tlmb_pkg::has_data_a(op));
    assign align = (32'h1 << req_size) - 32'h1;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_ready <= 1'b0;
            beat_q <= tlmb_pkg::CNT_RST;
            bus.a_valid <= 1'b0;
            bus.a_opcode <= tlmb_pkg::TLMB_GET;
            bus.a_param <= '0;
            bus.a_size <= '0;
            bus.a_source <= '0;
            bus.a_address <= '0;
            bus.a_mask <= '0;
            bus.a_data <= '0;
            legal <= 1'b0;
        end
        else if (accept)
        begin
            req_ready <= 1'b0;
            bus.a_valid <= 1'b1;
            beat_q <= (beat_q == b1) ? tlmb_pkg::CNT_RST : beat_q + 1'b1;
            // header is frozen after the opening beat of a message
            if (beat_q == tlmb_pkg::CNT_RST)
            begin
                bus.a_opcode <= op;
                bus.a_param <= req_param;
                bus.a_size <= req_size;
                bus.a_source <= req_source;
                bus.a_address <= req_address;
                legal <= SUPPORTS[op] && req_size <= MAX_LG
                    && (req_address & align) == '0;
            end
            bus.a_mask <= (op == tlmb_pkg::TLMB_PUT_PART
                || op == tlmb_pkg::TLMB_ARITH || op == tlmb_pkg::TLMB_LOGIC)
                ? req_mask : '1;
            bus.a_data <= req_data;
        end
        else if (!bus.a_valid || bus.a_ready)
        begin
            bus.a_valid <= 1'b0;
            req_ready <= 1'b1;
        end
    end

    assign d_fire = bus.d_valid && bus.d_ready;
    assign d_b1 = tlmb_pkg::beats1(bus.d_size,
        tlmb_pkg::has_data_d(tlmb_pkg::tlmb_d_op_t'(bus.d_opcode)));

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus.d_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_opcode <= '0;
            rsp_source <= '0;
            rsp_data <= '0;
            rsp_first <= 1'b0;
            rsp_last <= 1'b0;
            rsp_done <= 1'b0;
            rsp_count <= tlmb_pkg::CNT_RST;
        end
        else
        begin
            // responses are never refused; user side takes pulses
            bus.d_ready <= 1'b1;
            rsp_valid <= d_fire;
            rsp_done <= d_fire && rsp_count == d_b1;
            if (d_fire)
            begin
                rsp_opcode <= bus.d_opcode;
                rsp_source <= bus.d_source;
                rsp_data <= bus.d_data;
                rsp_first <= rsp_count == tlmb_pkg::CNT_RST;
                rsp_last <= rsp_count == d_b1;
                rsp_count <= (rsp_count == d_b1) ? tlmb_pkg::CNT_RST
                    : rsp_count + 1'b1;
            end
        end
    end
endmodule

// >>> tlmb_asserts.sv
`timescale 1ns/100ps
module tlmb_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic a_valid,
    input wire logic a_ready,
    input wire logic [2:0] a_opcode,
    input wire logic [3:0] a_mask,
    input wire logic [31:0] a_address,
    input wire logic d_valid,
    input wire logic d_ready,
    input wire logic [2:0] d_opcode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic a_fire;
    assign a_fire = a_valid && a_ready;
    property p_a_hold; a_valid && !a_ready |=> a_valid && $stable(a_address);
    endproperty
    a_a_hold: assert property (p_a_hold) else $error("a beat moved");
    property p_get; a_fire && a_opcode == 3'h4 |->
        ##[2:40] d_valid && d_opcode == 3'h1;
    endproperty
    a_get: assert property (p_get) else $error("get not answered");
    property p_hint; a_fire && a_opcode == 3'h5 |->
        ##[2:40] d_valid && d_opcode == 3'h2;
    endproperty
    a_hint: assert property (p_hint) else $error("no hint ack");
    property p_arith; a_fire && a_opcode == 3'h2 |-> ##[2:40] d_opcode == 3'h1;
    endproperty
    a_arith: assert property (p_arith) else $error("arith no data");
    property p_logic; a_fire && a_opcode == 3'h3 |->
        ##[2:40] d_valid && d_opcode == 3'h1;
    endproperty
    a_logic: assert property (p_logic) else $error("logic no data");
    property p_full; a_valid && a_opcode == 3'h0 |-> a_mask == 4'hf;
    endproperty
    a_full: assert property (p_full) else $error("full put masked");
    property p_put; a_fire && a_opcode < 3'h2 |-> ##[1:40] d_valid && !d_opcode;
    endproperty
    a_put: assert property (p_put) else $error("put not acked");
    property p_one; d_valid && d_ready && d_opcode == 3'h0 |=> !d_valid;
    endproperty
    a_one: assert property (p_one) else $error("extra put ack");
endmodule

// >>> tlmb_tb_top.sv
`timescale 1ns/100ps
module tlmb_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    tlmb_pkg::tlmb_req_t req_kind = tlmb_pkg::TLMB_REQ_GET;
    logic [2:0] req_param = 3'h0, req_size = 3'h2, rsp_opcode;
    logic [3:0] req_source = 4'h3, req_mask = 4'h0, rsp_source;
    logic [31:0] req_address = 32'h0, req_data = 32'h0, rsp_data;
    logic req_mask_en = 1'b0;
    logic req_ready, legal, rsp_valid, rsp_first, rsp_last, rsp_done;
    logic [7:0] rsp_count;
    int fail_count = 0;
    int compares = 0;
    logic [31:0] at_d [9] = '{32'h3, 32'hffffffff, 32'h2, 32'h7, 32'h9,
        32'hf, 32'h1, 32'h3, 32'ha};
    logic [31:0] at_o [9] = '{32'h5, 32'h8, 32'hffffffff, 32'hffffffff,
        32'h7, 32'h9, 32'h6, 32'h7, 32'h3};
    logic [2:0] at_p [9] = '{3'h4, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h1, 3'h2,
        3'h3};
    always #10 sys_clk = ~sys_clk;
    tlmb_if tlmb_if_i ();
    tlmb_client tlmb_client_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(tlmb_if_i.client), .req_valid(req_valid), .req_ready(req_ready),
        .req_kind(req_kind), .req_param(req_param), .req_size(req_size),
        .req_source(req_source), .req_address(req_address),
        .req_data(req_data), .req_mask(req_mask), .req_mask_en(req_mask_en),
        .legal(legal), .rsp_valid(rsp_valid), .rsp_opcode(rsp_opcode),
        .rsp_source(rsp_source), .rsp_data(rsp_data), .rsp_first(rsp_first),
        .rsp_last(rsp_last), .rsp_done(rsp_done), .rsp_count(rsp_count));
    tlmb_manager tlmb_manager_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(tlmb_if_i.manager), .a_first(), .a_last(), .a_done(),
        .a_count(), .d_first(), .d_last(), .d_done(), .d_count(),
        .pf_valid(), .pf_exclusive(), .pf_address());
    tlmb_asserts tlmb_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .a_valid(tlmb_if_i.a_valid), .a_ready(tlmb_if_i.a_ready),
        .a_opcode(tlmb_if_i.a_opcode), .a_mask(tlmb_if_i.a_mask),
        .a_address(tlmb_if_i.a_address), .d_valid(tlmb_if_i.d_valid),
        .d_ready(tlmb_if_i.d_ready), .d_opcode(tlmb_if_i.d_opcode));
    task automatic complete_run;
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic op(input logic [2:0] k, p, s, input logic [31:0] a, d,
        input logic [3:0] m, input logic lg);
        while (req_ready !== 1'b1)
            @(negedge sys_clk);
        req_kind = tlmb_pkg::tlmb_req_t'(k);
        req_param = p;
        req_size = s;
        req_address = a;
        req_data = d;
        req_mask = m;
        req_mask_en = |m;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        chk("legal", {31'h0, lg}, {31'h0, legal});
    endtask
    // counts assume at most two beats
    task automatic rsp(input logic [2:0] eo, input logic [31:0] ed,
        input logic f, l);
        int i = 0;
        while (rsp_valid !== 1'b1 && i < 100)
        begin
            @(negedge sys_clk);
            i++;
        end
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        chk("rsp_opcode", {29'h0, eo}, {29'h0, rsp_opcode});
        chk("rsp_source", 32'h3, {28'h0, rsp_source});
        if (eo == 3'h1)
            chk("rsp_data", ed, rsp_data);
        chk("rsp_first", {31'h0, f}, {31'h0, rsp_first});
        chk("rsp_last", {31'h0, l}, {31'h0, rsp_last});
        chk("rsp_done", {31'h0, l}, {31'h0, rsp_done});
        chk("rsp_count", {31'h0, !l}, {24'h0, rsp_count});
        @(negedge sys_clk);
    endtask
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        op(3'h1, 3'h0, 3'h2, 32'h10, 32'h5, 4'h0, 1'b1);
        rsp(3'h0, 32'h0, 1'b1, 1'b1);
        for (int j = 0; j < 9; j++)
        begin
            op(j < 5 ? 3'h2 : 3'h3, at_p[j], 3'h2, 32'h10, at_d[j], 4'hf, 1'b1);
            rsp(3'h1, at_o[j], 1'b1, 1'b1);
        end
        op(3'h0, 3'h0, 3'h2, 32'h10, 32'h0, 4'h0, 1'b1);
        rsp(3'h1, 32'ha, 1'b1, 1'b1);
        op(3'h1, 3'h0, 3'h3, 32'h20, 32'h1, 4'h0, 1'b1);
        op(3'h1, 3'h0, 3'h3, 32'h20, 32'h2, 4'h0, 1'b1);
        rsp(3'h0, 32'h0, 1'b1, 1'b1);
        op(3'h0, 3'h0, 3'h3, 32'h20, 32'h0, 4'h0, 1'b1);
        rsp(3'h1, 32'h1, 1'b1, 1'b0);
        rsp(3'h1, 32'h2, 1'b0, 1'b1);
        op(3'h1, 3'h0, 3'h2, 32'h20, 32'hff, 4'h1, 1'b1);
        rsp(3'h0, 32'h0, 1'b1, 1'b1);
        op(3'h0, 3'h0, 3'h2, 32'h20, 32'h0, 4'h0, 1'b1);
        rsp(3'h1, 32'hff, 1'b1, 1'b1);
        for (int h = 0; h < 2; h++)
        begin
            op(3'h4, h[2:0], 3'h2, 32'h10, 32'h0, 4'h0, 1'b1);
            rsp(3'h2, 32'h0, 1'b1, 1'b1);
        end
        // misaligned read is carried, only flagged
        op(3'h0, 3'h0, 3'h2, 32'h11, 32'h0, 4'h0, 1'b0);
        rsp(3'h1, 32'ha, 1'b1, 1'b1);
        complete_run();
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
endmodule
